// ### rtl/put_pkg.sv
// shared constants and types of the pacer and user timer block
// Operation
// - Conversion triggers come at the 2 MHz reference divided by both pacer divisors in cascade.
// - A pacer divisor of zero stops the conversion triggers completely.
// - The two pacer counters only divide the reference for the trigger and do nothing else.
// - The user counter counts reference ticks or, when set to, edges of the external clock pin.
// - The user counter offers counting modes zero to five, each chosen in the control register and run with a loaded count.
// - Software can read the live count of the user counter while it runs.
// - One-shot mode with a count of zero never arms the user counter and holds its output high.
// - Stopping acquisition disables the trigger and halts the pacer but keeps the sample count.
package put_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int REF_HZ = 2_000_000;
  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(CLK_HZ / REF_HZ - 1);
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [AW-1:0] A_DIV1 = 4'h0;
  localparam logic [AW-1:0] A_DIV2 = 4'h1;
  localparam logic [AW-1:0] A_ULOAD = 4'h2;
  localparam logic [AW-1:0] A_UCTRL = 4'h3;
  localparam logic [AW-1:0] A_UCNT = 4'h4;
  localparam logic [AW-1:0] A_ACQ = 4'h5;
  localparam logic [AW-1:0] A_SAMPLES = 4'h6;
  localparam logic [AW-1:0] A_STATUS = 4'h7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SRC_BIT = 3;
  localparam int ACQ_EN_BIT = 0;
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_ARM_BIT = 2;
  localparam int STAT_CNT_BIT = 3;
  localparam logic [DW-1:0] RST_DIV = 16'h0000;
  localparam logic [DW-1:0] RST_LOAD = 16'h0000;
  localparam logic [DW-1:0] CNT_ONE = 16'h0001;
  localparam logic [DW-1:0] CNT_TWO = 16'h0002;

  typedef enum logic [2:0] {
    M_TC_INT,
    M_ONE_SHOT,
    M_RATE,
    M_SQUARE,
    M_SW_STROBE,
    M_HW_STROBE
  } put_mode_e;

  // codes six and seven fold onto rate and square wave
  function automatic put_mode_e put_fold_mode(input logic [2:0] code);
    put_mode_e m;
    unique case (code)
      3'h0: m = M_TC_INT;
      3'h1: m = M_ONE_SHOT;
      3'h2: m = M_RATE;
      3'h3: m = M_SQUARE;
      3'h4: m = M_SW_STROBE;
      3'h5: m = M_HW_STROBE;
      3'h6: m = M_RATE;
      default: m = M_SQUARE;
    endcase
    return m;
  endfunction
endpackage

// ### rtl/put_sync.sv
// two-flop synchroniser for one pin
module put_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } put_sync_s;

  put_sync_s st_reg;
  put_sync_s st_next;

  always_comb
  begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule

// ### rtl/put_div.sv
// one pacer divider stage: terminal-count pulse every divisor steps
module put_div
  import put_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic step,
  input wire logic [put_pkg::DW-1:0] divisor,
  output logic tc
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic tc;
  } put_div_s;

  put_div_s st_reg;
  put_div_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.tc = 1'b0;
    if (!run || divisor == '0)
    begin
      st_next.cnt = '0;
    end
    else if (st_reg.cnt == '0)
    begin
      // arm on start so the first period is a full one
      st_next.cnt = divisor;
    end
    else if (step)
    begin
      if (st_reg.cnt == CNT_ONE)
      begin
        st_next.cnt = divisor;
        st_next.tc = 1'b1;
      end
      else
      begin
        st_next.cnt = st_reg.cnt - CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  assign tc = st_reg.tc;
endmodule

// ### rtl/put_top.sv
// pacer trigger and user timer with register port
//
// Local design decisions: the address-and-strobe port and the register addresses.
module put_top (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic [put_pkg::AW-1:0] ADDR,
  input wire logic [put_pkg::DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [put_pkg::DW-1:0] RDATA,
  input wire logic EXT_CLK,
  input wire logic GATE,
  output logic CONV_TRIG,
  output logic USER_OUT
);
  import put_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic tick;
    logic [DW-1:0] div1;
    logic [DW-1:0] div2;
    logic [DW-1:0] load;
    logic [DW-1:0] cnt;
    put_mode_e mode;
    logic src_ext;
    logic trig_en;
    logic [DW-1:0] samples;
    logic out;
    logic armed;
    logic counting;
    logic gate_d;
    logic ext_d;
    logic [DW-1:0] rdata;
  } put_top_s;

  put_top_s st_reg;
  put_top_s st_next;
  logic ext_s;
  logic gate_s;
  logic tc1;
  logic tc2;
  logic ext_rise;
  logic gate_rise;
  logic step;
  logic wr_ctrl;
  logic wr_load;

  put_sync u_sync_ext (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .d(EXT_CLK),
    .q(ext_s)
  );

  put_sync u_sync_gate (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .d(GATE),
    .q(gate_s)
  );

  // pacer stages see only the enable and their step: the reference tick for the first, its terminal count for the second
  put_div u_div1 (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .run(st_reg.trig_en),
    .step(st_reg.tick),
    .divisor(st_reg.div1),
    .tc(tc1)
  );

  put_div u_div2 (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .run(st_reg.trig_en),
    .step(tc1),
    .divisor(st_reg.div2),
    .tc(tc2)
  );

  assign ext_rise = ext_s & ~st_reg.ext_d;
  assign gate_rise = gate_s & ~st_reg.gate_d;
  assign step = st_reg.src_ext ? ext_rise : st_reg.tick;
  assign wr_ctrl = WR && ADDR == A_UCTRL;
  assign wr_load = WR && ADDR == A_ULOAD;

  always_comb
  begin
    st_next = st_reg;
    st_next.gate_d = gate_s;
    st_next.ext_d = ext_s;
    st_next.rdata = '0;
    // reference tick at 2 MHz
    st_next.tick = 1'b0;
    if (st_reg.pre == TICK_LAST)
    begin
      st_next.pre = '0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.pre = st_reg.pre + PRE_W'(1);
    end

    // samples counted on each issued trigger
    if (tc2)
    begin
      st_next.samples = st_reg.samples + CNT_ONE;
    end

    if (WR)
    begin
      unique case (ADDR)
        A_DIV1: st_next.div1 = WDATA;
        A_DIV2: st_next.div2 = WDATA;
        A_ACQ:
        begin
          st_next.trig_en = WDATA[ACQ_EN_BIT];
          if (WDATA[ACQ_EN_BIT] && !st_reg.trig_en)
          begin
            // a trailing trigger in the same cycle still counts
            st_next.samples = tc2 ? CNT_ONE : '0;
          end
        end
        default: ;
      endcase
    end

    if (wr_ctrl)
    begin
      st_next.mode = put_fold_mode(WDATA[CTRL_MODE_LSB +: 3]);
      st_next.src_ext = WDATA[CTRL_SRC_BIT];
      st_next.counting = 1'b0;
      st_next.armed = 1'b0;
      st_next.out = put_fold_mode(WDATA[CTRL_MODE_LSB +: 3]) != M_TC_INT;
    end
    else if (wr_load)
    begin
      st_next.load = WDATA;
      unique case (st_reg.mode)
        M_ONE_SHOT, M_HW_STROBE:
        begin
          // a zero count never arms: output parks high
          st_next.armed = WDATA != '0;
          st_next.out = 1'b1;
        end
        default:
        begin
          st_next.cnt = WDATA;
          st_next.counting = 1'b1;
          st_next.out = st_reg.mode != M_TC_INT;
        end
      endcase
    end
    else if (gate_rise && st_reg.armed &&
             (st_reg.mode == M_ONE_SHOT || st_reg.mode == M_HW_STROBE))
    begin
      st_next.cnt = st_reg.load;
      st_next.counting = 1'b1;
      st_next.out = st_reg.mode != M_ONE_SHOT;
    end
    else if (st_reg.counting && step)
    begin
      unique case (st_reg.mode)
        M_TC_INT:
        begin
          if (gate_s)
          begin
            st_next.cnt = st_reg.cnt - CNT_ONE;
            if (st_reg.cnt == CNT_ONE)
            begin
              st_next.out = 1'b1;
              st_next.counting = 1'b0;
            end
          end
        end
        M_ONE_SHOT:
        begin
          st_next.cnt = st_reg.cnt - CNT_ONE;
          if (st_reg.cnt == CNT_ONE)
          begin
            st_next.out = 1'b1;
            st_next.counting = 1'b0;
          end
        end
        M_RATE:
        begin
          if (gate_s)
          begin
            st_next.cnt = st_reg.cnt == CNT_ONE ? st_reg.load : st_reg.cnt - CNT_ONE;
            st_next.out = st_reg.cnt != CNT_TWO;
          end
        end
        M_SQUARE:
        begin
          if (gate_s)
          begin
            if (st_reg.cnt <= CNT_TWO)
            begin
              st_next.cnt = st_reg.load;
              st_next.out = ~st_reg.out;
            end
            else
            begin
              st_next.cnt = st_reg.cnt - CNT_TWO;
            end
          end
        end
        M_SW_STROBE, M_HW_STROBE:
        begin
          // strobe lasts one count step, then the counter idles
          if (!st_reg.out)
          begin
            st_next.out = 1'b1;
            st_next.counting = 1'b0;
          end
          else if (gate_s || st_reg.mode == M_HW_STROBE)
          begin
            st_next.cnt = st_reg.cnt - CNT_ONE;
            st_next.out = st_reg.cnt != CNT_ONE;
          end
        end
        default: ;
      endcase
    end

    // a low gate forces the periodic modes high
    if (!gate_s && (st_reg.mode == M_RATE || st_reg.mode == M_SQUARE) && !wr_ctrl)
    begin
      st_next.out = 1'b1;
    end

    if (RD)
    begin
      unique case (ADDR)
        A_DIV1: st_next.rdata = st_reg.div1;
        A_DIV2: st_next.rdata = st_reg.div2;
        A_ULOAD: st_next.rdata = st_reg.load;
        A_UCTRL: st_next.rdata = {12'h000, st_reg.src_ext, st_reg.mode};
        A_UCNT: st_next.rdata = st_reg.cnt;
        A_ACQ: st_next.rdata = {15'h0000, st_reg.trig_en};
        A_SAMPLES: st_next.rdata = st_reg.samples;
        A_STATUS:
        begin
          st_next.rdata[STAT_OUT_BIT] = st_reg.out;
          st_next.rdata[STAT_RUN_BIT] = st_reg.trig_en;
          st_next.rdata[STAT_ARM_BIT] = st_reg.armed;
          st_next.rdata[STAT_CNT_BIT] = st_reg.counting;
        end
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_reg <= '0;
      st_reg.div1 <= RST_DIV;
      st_reg.div2 <= RST_DIV;
      st_reg.load <= RST_LOAD;
      st_reg.mode <= M_ONE_SHOT;
      st_reg.out <= 1'b1;
    end
    else if (CE)
    begin
      st_reg <= st_next;
    end
  end

  assign RDATA = st_reg.rdata;
  assign CONV_TRIG = tc2;
  assign USER_OUT = st_reg.out;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N || !CE);

  AST_TRIG_NEEDS_RUN: assert property (CONV_TRIG |-> $past(st_reg.trig_en))
    else $error("trigger while pacer disabled");
  AST_ZERO_DIV_SILENT: assert property
    ($past(st_reg.div1 == '0 || st_reg.div2 == '0) |-> !CONV_TRIG)
    else $error("trigger with a zero divisor");
  AST_TRIG_FROM_TC1: assert property (CONV_TRIG |-> $past(tc1))
    else $error("trigger not caused by first stage");
  AST_TRIG_ONE_CYCLE: assert property (CONV_TRIG |=> !CONV_TRIG)
    else $error("trigger longer than one cycle");
  AST_TC1_FROM_TICK: assert property (tc1 |-> $past(st_reg.tick) && $past(st_reg.trig_en))
    else $error("first stage not driven by reference");
  AST_TICK_GAP: assert property (st_reg.tick |=> !st_reg.tick [*8])
    else $error("reference tick too fast");
  AST_STOP_HIGH: assert property
    (st_reg.mode == M_ONE_SHOT && !st_reg.armed && !st_reg.counting && !wr_ctrl |=> USER_OUT)
    else $error("stopped user counter output not high");
  AST_READBACK: assert property (RD && ADDR == A_UCNT |=> RDATA == $past(st_reg.cnt))
    else $error("user count read back wrong");
  AST_SRC_HOLD: assert property
    (!step && !WR && !gate_rise |=> $stable(st_reg.cnt))
    else $error("user count moved without a clock step");
  AST_MODE0_END: assert property
    (st_reg.mode == M_TC_INT && st_reg.counting && step && gate_s && !WR &&
     st_reg.cnt == CNT_ONE |=> USER_OUT && !st_reg.counting)
    else $error("mode zero output not high at terminal count");
  AST_SAMPLES_HELD: assert property
    (!st_reg.trig_en && !WR && !CONV_TRIG |=> $stable(st_reg.samples))
    else $error("sample count changed while stopped");

  COV_TRIG: cover property (CONV_TRIG);
  COV_RATE_LOW: cover property (st_reg.mode == M_RATE && $fell(USER_OUT));
  COV_ONE_SHOT: cover property (st_reg.mode == M_ONE_SHOT && $rose(USER_OUT));
  COV_STOP: cover property ($fell(st_reg.trig_en));
endmodule

// ### verif/put_far_model.sv
// far-side model: trigger sink and external clock source
module put_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_trig,
  output logic ext_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc;
  int trigs;
  int highs;
  int stamp;
  int period;
  logic conv_d;
  initial ext_clk = 1'b0;
  // spacing of the last two triggers and the total width of all triggers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc <= 0;
      trigs <= 0;
      highs <= 0;
      stamp <= 0;
      period <= 0;
      conv_d <= 1'b0;
    end
    else
    begin
      cyc <= cyc + 1;
      conv_d <= conv_trig;
      if (conv_trig)
      begin
        highs <= highs + 1;
      end
      // triggers counted on rising edges, width counted in cycles
      if (conv_trig && !conv_d)
      begin
        trigs <= trigs + 1;
        period <= cyc - stamp;
        stamp <= cyc;
      end
    end
  end
  // clock stands still low between bursts
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// ### verif/put_top_bench.sv
// self-checking bench of the pacer and user timer
module put_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import put_pkg::*;
  typedef struct {
    string nm;
    logic [DW-1:0] lo;
    logic [DW-1:0] hi;
  } put_note_s;
  logic clk;
  logic rst_n;
  logic wr;
  logic rd;
  logic rd_d = 1'b0;
  logic ce;
  logic gate;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic trig;
  logic uout;
  logic ext;
  logic seen;
  logic [31:0] seed = 32'he633;
  logic [DW-1:0] n;
  put_note_s q[$];
  put_note_s nt;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int k;

  put_top u_put_top (.CLK(clk), .RESET_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .EXT_CLK(ext), .GATE(gate), .CONV_TRIG(trig),
    .USER_OUT(uout));
  put_far_model u_put_far_model (.clk(clk), .rst_n(rst_n), .conv_trig(trig), .ext_clk(ext));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // an idle edge before each strobe keeps one assignment per time step
  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] lo,
    input logic [DW-1:0] hi);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    q.push_back('{nm, lo, hi});
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic watch(input int m, input logic v, output logic s);
    s = 1'b0;
    repeat (m)
    begin
      @(posedge clk);
      if (uout === v)
        s = 1'b1;
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_d)
    begin
      nt = q.pop_front();
      if (rdata >= nt.lo && rdata <= nt.hi)
        check_count++;
      else
        chk(nt.nm, nt.lo, rdata);
    end
    rd_d <= rd;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      give_verdict();
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    gate = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rreg("div2", A_DIV2, RST_DIV, RST_DIV);
    rreg("uctrl", A_UCTRL, 16'h0001, 16'h0001);
    rreg("acq", A_ACQ, 16'h0000, 16'h0000);
    rreg("status", A_STATUS, 16'h0001, 16'h0001);
    rreg("unmapped", 4'hc, 16'h0000, 16'h0000);
    wreg(A_UCNT, 16'h1234);
    rreg("ucnt", A_UCNT, RST_LOAD, RST_LOAD);
    seed = xs(seed);
    wreg(A_DIV1, seed[15:0]);
    rreg("div1", A_DIV1, seed[15:0], seed[15:0]);
    $display("register test done");
    wreg(A_DIV1, 16'h0003);
    wreg(A_DIV2, 16'h0007);
    wreg(A_ACQ, 16'h0001);
    k = 0;
    while (u_put_far_model.trigs < 3 && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    wreg(A_ACQ, 16'h0000);
    chk("period", 16'h041a, u_put_far_model.period[15:0]);
    chk("width", 16'h0003, u_put_far_model.highs[15:0]);
    rreg("samples", A_SAMPLES, 16'h0003, 16'h0003);
    repeat (2200) @(posedge clk);
    chk("halted", 16'h0003, u_put_far_model.trigs[15:0]);
    wreg(A_DIV2, RST_DIV);
    wreg(A_ACQ, 16'h0001);
    repeat (2200) @(posedge clk);
    chk("div zero", 16'h0003, u_put_far_model.trigs[15:0]);
    wreg(A_ACQ, 16'h0000);
    $display("pacer test done");
    seed = xs(seed);
    n = 16'h0004 + 16'(seed[2:0]);
    wreg(A_UCTRL, 16'h0000);
    wreg(A_ULOAD, n);
    repeat (100) @(posedge clk);
    rreg("ucnt live", A_UCNT, n - 16'h0003, n - 16'h0001);
    // a low enable freezes the count and the reference tick alike
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    ce <= 1'b1;
    rreg("ucnt frozen", A_UCNT, n - 16'h0003, n - 16'h0001);
    chk("count low", 16'h0000, uout);
    repeat (50 * int'(n) - 90) @(posedge clk);
    chk("count high", 16'h0001, uout);
    for (int m = 0; m < 6; m++)
    begin
      gate <= 1'b0;
      wreg(A_UCTRL, 16'(m));
      wreg(A_ULOAD, 16'h0004);
      rreg("mode", A_UCTRL, 16'(m), 16'(m));
      gate <= 1'b1;
      watch(500, 1'b0, seen);
      chk("mode out", 16'h0001, seen);
    end
    wreg(A_UCTRL, 16'h0006);
    rreg("fold six", A_UCTRL, 16'h0002, 16'h0002);
    wreg(A_UCTRL, 16'h0007);
    rreg("fold seven", A_UCTRL, 16'h0003, 16'h0003);
    $display("mode test done");
    wreg(A_UCTRL, 16'h0008);
    wreg(A_ULOAD, 16'h0003);
    repeat (300) @(posedge clk);
    chk("ext idle", 16'h0000, uout);
    u_put_far_model.ext_pulses(2);
    chk("ext two", 16'h0000, uout);
    u_put_far_model.ext_pulses(1);
    repeat (4) @(posedge clk);
    chk("ext three", 16'h0001, uout);
    $display("event test done");
    gate <= 1'b0;
    wreg(A_UCTRL, 16'h0001);
    wreg(A_ULOAD, RST_LOAD);
    gate <= 1'b1;
    watch(300, 1'b0, seen);
    chk("stop out", 16'h0000, seen);
    rreg("stop status", A_STATUS, 16'h0001, 16'h0001);
    repeat (2) @(posedge clk);
    $display("stop test done");
    give_verdict();
  end
endmodule
